// File: core/bsfs_pkg.sv
package bsfs_pkg;

    localparam int unsigned CLK_MHZ = 250;

    // Phase timeouts, microseconds as printed
    localparam int unsigned LINEAR_CHARGE_FIRST_TIMEOUT_US = 512;
    localparam int unsigned LINEAR_CHARGE_SECOND_TIMEOUT_US = 1024;
    localparam int unsigned RAMP_STALL_US   = 64;
    // Longer intervals, milliseconds as printed except TYP_START_US, which is in microseconds
    localparam int unsigned ILIM_FAULT_MS   = 2;
    localparam int unsigned RESTART_MS      = 20;
    localparam int unsigned TYP_START_US    = 1000;

    // Internal time base: one tick per microsecond
    localparam int unsigned TICK_CYCLES = CLK_MHZ;
    localparam logic [7:0]  TICK_LAST   = 8'(TICK_CYCLES - 1);

    localparam logic [15:0] LINEAR_CHARGE_FIRST_TICKS  = 16'(LINEAR_CHARGE_FIRST_TIMEOUT_US);
    localparam logic [15:0] LINEAR_CHARGE_SECOND_TICKS  = 16'(LINEAR_CHARGE_SECOND_TIMEOUT_US);
    localparam logic [15:0] RAMP_TICKS  = 16'(RAMP_STALL_US);
    localparam logic [15:0] ILIM_TICKS  = 16'(ILIM_FAULT_MS * 1000);
    localparam logic [15:0] RST_TICKS   = 16'(RESTART_MS * 1000);

    // Reference ramp: steps per microsecond tick, slow when output lags
    localparam logic [7:0]  REF_FULL    = 8'hFF;
    localparam logic [7:0]  REF_STEP    = 8'h04;
    localparam logic [7:0]  REF_STEP_SLOW = 8'h01;

    // Switching: 250 MHz / 100 = 2.5 MHz
    localparam logic [6:0]  SW_PERIOD   = 7'(100);
    localparam logic [6:0]  SW_LAST     = 7'(99);

    localparam logic [1:0]  ILIM_HALF   = 2'h1;
    localparam logic [1:0]  ILIM_FULL   = 2'h2;
    localparam logic [1:0]  ILIM_NONE   = 2'h0;

    localparam logic [2:0]  SYNC_RESET  = 3'h0;

    typedef enum logic [2:0] {
        BSFS_SHUTDOWN  = 3'b000,
        BSFS_LIN_FIRST = 3'b001,
        BSFS_LIN_SECOND = 3'b010,
        BSFS_RAMP      = 3'b011,
        BSFS_REGULATE  = 3'b100,
        BSFS_FAULT     = 3'b101,
        BSFS_THERMAL   = 3'b110
    } bsfs_state_t;

    typedef struct packed {
        logic enable;
        logic vin_above_uvlo;
        logic vout_near_vin;
        logic vout_at_target;
        logic vout_tracking;
        logic vout_slow;
        logic current_limit;
        logic vin_over_vout;
        logic die_hot;
        logic die_cooled;
        logic light_load;
    } bsfs_sense_t;

    typedef struct packed {
        logic       bias_on;
        logic       precharge_on;
        logic       iso_input_on;
        logic       iso_output_on;
        logic       switch_gate;
        logic [1:0] pulse_ilim;
        logic [7:0] ref_level;
        logic       startup_done;
        logic       fault_active;
    } bsfs_drive_t;

endpackage

// File: core/bsfs_sync.sv
module bsfs_sync
    import bsfs_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic       out_q;
    logic       out_d;

    always_comb begin
        stage_d = {stage_q[1:0], async_in};
        // Change accepted only when second and third stages agree
        out_d   = (stage_q[1] == stage_q[2]) ? stage_q[2] : out_q;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stage_q <= SYNC_RESET;
            out_q   <= 1'b0;
        end else begin
            stage_q <= stage_d;
            out_q   <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule

// File: core/bsfs_sequencer.sv
module bsfs_sequencer
    import bsfs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire bsfs_pkg::bsfs_sense_t sense,
    output bsfs_pkg::bsfs_drive_t      drive,
    output bsfs_pkg::bsfs_state_t      phase
);
    import bsfs_pkg::*;

    bsfs_sense_t s;

    // Every analog comparator and the enable pin are asynchronous
    genvar gi;
    generate
        for (gi = 0; gi < $bits(bsfs_sense_t); gi++) begin : g_sync
            bsfs_sync u_sync (
                .clk_sys  (clk_sys),
                .reset    (reset),
                .async_in (sense[gi]),
                .sync_out (s[gi])
            );
        end
    endgenerate

    // Microsecond time base
    logic [7:0]  tick_cnt_q;
    logic [7:0]  tick_cnt_d;
    logic        tick;

    always_comb begin
        tick       = (tick_cnt_q == TICK_LAST);
        tick_cnt_d = tick ? 8'h00 : tick_cnt_q + 8'h01;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tick_cnt_q <= 8'h00;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    // Sequencer state
    bsfs_state_t state_q;
    bsfs_state_t state_d;
    logic [15:0] phase_cnt_q;
    logic [15:0] phase_cnt_d;
    logic [15:0] stall_cnt_q;
    logic [15:0] stall_cnt_d;
    logic [7:0]  ref_q;
    logic [7:0]  ref_d;
    logic        done_q;
    logic        done_d;
    logic        enter;

    always_comb begin
        state_d     = state_q;
        enter       = 1'b0;
        phase_cnt_d = phase_cnt_q;
        stall_cnt_d = stall_cnt_q;
        ref_d       = ref_q;
        done_d      = done_q;

        if (tick) begin
            phase_cnt_d = phase_cnt_q + 16'h0001;
        end

        case (state_q)
            BSFS_SHUTDOWN: begin
                done_d = 1'b0;
                if (s.enable && s.vin_above_uvlo) begin
                    state_d = BSFS_LIN_FIRST;
                end
            end
            BSFS_LIN_FIRST: begin
                if (s.vout_near_vin) begin
                    state_d = BSFS_RAMP;
                end else if (phase_cnt_q >= LINEAR_CHARGE_FIRST_TICKS) begin
                    state_d = BSFS_LIN_SECOND;
                end
            end
            BSFS_LIN_SECOND: begin
                if (s.vout_near_vin) begin
                    state_d = BSFS_RAMP;
                end else if (phase_cnt_q >= LINEAR_CHARGE_SECOND_TICKS) begin
                    state_d = BSFS_FAULT;
                end
            end
            BSFS_RAMP: begin
                if (tick) begin
                    // Big output cap: slower reference steps cap input current
                    if (s.vout_slow) begin
                        ref_d = (ref_q > REF_FULL - REF_STEP_SLOW) ? REF_FULL
                              : ref_q + REF_STEP_SLOW;
                    end else begin
                        ref_d = (ref_q > REF_FULL - REF_STEP) ? REF_FULL
                              : ref_q + REF_STEP;
                    end
                    stall_cnt_d = s.vout_tracking ? 16'h0000
                                : stall_cnt_q + 16'h0001;
                end
                if (s.vout_at_target) begin
                    state_d = BSFS_REGULATE;
                    done_d  = 1'b1;
                end else if (stall_cnt_q > RAMP_TICKS) begin
                    state_d = BSFS_FAULT;
                end
            end
            BSFS_REGULATE: begin
                if (tick) begin
                    stall_cnt_d = s.current_limit ? stall_cnt_q + 16'h0001
                                : 16'h0000;
                end
                if (!s.current_limit) begin
                    stall_cnt_d = 16'h0000;
                end
                if (stall_cnt_q >= ILIM_TICKS) begin
                    state_d = BSFS_FAULT;
                end else if (done_q && s.vin_over_vout) begin
                    state_d = BSFS_FAULT;
                end
            end
            BSFS_FAULT: begin
                if (phase_cnt_q >= RST_TICKS) begin
                    state_d = BSFS_SHUTDOWN;
                end
            end
            BSFS_THERMAL: begin
                if (s.die_cooled) begin
                    state_d = BSFS_SHUTDOWN;
                end
            end
            default: begin
                state_d = BSFS_SHUTDOWN;
            end
        endcase

        // Under-lockout only matters once a phase is active
        if (state_q != BSFS_SHUTDOWN && state_q != BSFS_FAULT
            && state_q != BSFS_THERMAL && !s.vin_above_uvlo) begin
            state_d = BSFS_FAULT;
        end
        if (s.die_hot) begin
            state_d = BSFS_THERMAL;
        end
        if (!s.enable) begin
            state_d = BSFS_SHUTDOWN;
        end

        enter = (state_d != state_q);
        if (enter) begin
            phase_cnt_d = 16'h0000;
            stall_cnt_d = 16'h0000;
            if (state_d == BSFS_RAMP) begin
                ref_d = 8'h00;
            end
        end
        if (state_d == BSFS_SHUTDOWN || state_d == BSFS_FAULT) begin
            done_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q     <= BSFS_SHUTDOWN;
            phase_cnt_q <= 16'h0000;
            stall_cnt_q <= 16'h0000;
            ref_q       <= 8'h00;
            done_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            phase_cnt_q <= phase_cnt_d;
            stall_cnt_q <= stall_cnt_d;
            ref_q       <= ref_d;
            done_q      <= done_d;
        end
    end

    // Switching clock; pulse skipping at light load drops frequency
    logic [6:0] sw_cnt_q;
    logic [6:0] sw_cnt_d;
    logic       sw_q;
    logic       sw_d;
    logic       skip_q;
    logic       skip_d;
    logic       switching;

    always_comb begin
        switching = (state_q == BSFS_RAMP) || (state_q == BSFS_REGULATE);
        sw_cnt_d  = (!switching || sw_cnt_q == SW_LAST) ? 7'h00
                  : sw_cnt_q + 7'h01;
        skip_d    = skip_q;
        if (sw_cnt_q == SW_LAST) begin
            skip_d = s.light_load && !skip_q;
        end
        sw_d = switching && !skip_d && (sw_cnt_d < (SW_PERIOD >> 1));
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sw_cnt_q <= 7'h00;
            sw_q     <= 1'b0;
            skip_q   <= 1'b0;
        end else begin
            sw_cnt_q <= sw_cnt_d;
            sw_q     <= sw_d;
            skip_q   <= skip_d;
        end
    end

    // Registered drive outputs
    bsfs_drive_t drive_q;
    bsfs_drive_t drive_d;

    always_comb begin
        drive_d = '0;
        drive_d.pulse_ilim = ILIM_NONE;
        case (state_q)
            BSFS_LIN_FIRST, BSFS_LIN_SECOND: begin
                drive_d.bias_on      = 1'b1;
                drive_d.precharge_on = 1'b1;
            end
            BSFS_RAMP: begin
                drive_d.bias_on       = 1'b1;
                drive_d.iso_input_on  = 1'b1;
                drive_d.iso_output_on = 1'b1;
                drive_d.switch_gate   = sw_q;
                drive_d.pulse_ilim    = ILIM_HALF;
                drive_d.ref_level     = ref_q;
            end
            BSFS_REGULATE: begin
                drive_d.bias_on       = 1'b1;
                drive_d.iso_input_on  = 1'b1;
                drive_d.iso_output_on = 1'b1;
                drive_d.switch_gate   = sw_q;
                drive_d.pulse_ilim    = ILIM_FULL;
                drive_d.ref_level     = REF_FULL;
                drive_d.startup_done  = done_q;
            end
            BSFS_FAULT: begin
                drive_d.bias_on      = 1'b1;
                drive_d.fault_active = 1'b1;
            end
            default: begin
                drive_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            drive_q <= '0;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign drive = drive_q;
    assign phase = state_q;
endmodule

// File: bench/bsfs_seq_props.sv
module bsfs_seq_props
    import bsfs_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire bsfs_sense_t sense,
    input wire bsfs_drive_t drive,
    input wire bsfs_state_t phase
);
    timeunit 1ns;
    timeprecision 1ps;
    // Two ticks of slack: counting starts mid-tick, plus sync delay
    localparam int STALL_MAX = 66 * 250;
    logic [15:0] stall_q;
    logic [15:0] stall_d;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    always_comb begin
        stall_d = 16'h0000;
        if (phase == BSFS_RAMP && !sense.vout_tracking) begin
            stall_d = stall_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            stall_q <= 16'h0000;
        end else begin
            stall_q <= stall_d;
        end
    end

    chk_off_disabled: assert property (!sense.enable [*8] |=>
        phase == BSFS_SHUTDOWN && !drive.bias_on && !drive.iso_input_on
        && !drive.iso_output_on) else $error("block on while disabled");
    chk_lin_source: assert property (
        (phase inside {BSFS_LIN_FIRST, BSFS_LIN_SECOND}) [*2]
        |-> drive.precharge_on && !drive.switch_gate)
        else $error("precharge source off in linear phase");
    chk_ramp_entry: assert property ($changed(phase) &&
        phase == BSFS_RAMP |-> $past(phase) inside
        {BSFS_LIN_FIRST, BSFS_LIN_SECOND}) else $error("bad ramp entry");
    chk_ramp_half: assert property ((phase == BSFS_RAMP) [*2]
        |-> drive.pulse_ilim == ILIM_HALF) else $error("ramp limit wrong");
    chk_ramp_stall: assert property (stall_q <= STALL_MAX)
        else $error("stalled ramp not faulted");
    chk_reg_entry: assert property ($changed(phase) &&
        phase == BSFS_REGULATE |-> $past(phase) == BSFS_RAMP)
        else $error("regulate entered without ramp");
    chk_fault_iso: assert property ((phase == BSFS_FAULT) [*2]
        |-> !drive.switch_gate && !drive.iso_input_on
        && !drive.iso_output_on && !drive.precharge_on)
        else $error("fault state not isolated");
    chk_uvlo_fault: assert property ((sense.enable &&
        !sense.die_hot && !sense.vin_above_uvlo) [*8] |-> phase inside
        {BSFS_SHUTDOWN, BSFS_FAULT, BSFS_THERMAL})
        else $error("active with input under lockout");
    chk_hot_off: assert property ((sense.enable && sense.die_hot
        && !sense.die_cooled) [*8] |=> phase == BSFS_THERMAL
        && !drive.bias_on) else $error("hot die not shut down");
    chk_rev_fault: assert property (phase == BSFS_REGULATE &&
        $rose(sense.vin_over_vout) |-> ##[1:8] phase == BSFS_FAULT)
        else $error("reverse rail not faulted");

    cov_regulate: cover property (phase == BSFS_REGULATE);
    cov_ramp_fault: cover property (phase == BSFS_FAULT
        && $past(phase) == BSFS_RAMP);
    cov_thermal: cover property (phase == BSFS_THERMAL);
endmodule

bind bsfs_sequencer bsfs_seq_props u_props (
    .clk_sys (clk_sys),
    .reset   (reset),
    .sense   (sense),
    .drive   (drive),
    .phase   (phase)
);

// File: bench/bsfs_rail_model.sv
module bsfs_rail_model
    import bsfs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire bsfs_drive_t drive,
    input  wire logic        en,
    input  wire logic        vin_ok,
    input  wire logic        stall,
    input  wire logic        rev,
    input  wire logic        heavy,
    input  wire logic        hot,
    input  wire logic        cooled,
    input  wire logic        slow,
    input  wire logic        light,
    input  wire logic [15:0] charge_dly,
    output bsfs_sense_t      sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] chg_q;
    logic [15:0] chg_d;

    always_comb begin
        chg_d = chg_q;
        if (!drive.bias_on || drive.fault_active) begin
            chg_d = 16'h0000; // Load drains the rail once isolated
        end else if (drive.precharge_on && chg_q != 16'hFFFF) begin
            chg_d = chg_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            chg_q <= 16'h0000;
        end else begin
            chg_q <= chg_d;
        end
    end

    assign sense = '{enable: en, vin_above_uvlo: vin_ok,
        vout_near_vin: chg_q >= charge_dly,
        vout_at_target: chg_q >= charge_dly && !stall
            && drive.ref_level == REF_FULL,
        vout_tracking: !stall, vout_slow: slow,
        current_limit: heavy && drive.startup_done,
        vin_over_vout: rev, die_hot: hot, die_cooled: cooled,
        light_load: light};
endmodule

// File: bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bsfs_pkg::*;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        en = 1'b0;
    logic        vin_ok = 1'b1;
    logic        stall = 1'b0;
    logic        rev = 1'b0;
    logic        heavy = 1'b0;
    logic        hot = 1'b0;
    logic        cooled = 1'b0;
    logic        slow = 1'b0;
    logic        light = 1'b0;
    logic [15:0] dly = 16'h0040;
    bsfs_sense_t sense;
    bsfs_drive_t drive;
    bsfs_state_t phase;
    int          miscompares = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          seed = 5559;

    bsfs_sequencer DUT (.clk_sys(clk_sys), .reset(reset), .sense(sense),
        .drive(drive), .phase(phase));
    bsfs_rail_model rail (.clk_sys(clk_sys), .reset(reset), .drive(drive),
        .en(en), .vin_ok(vin_ok), .stall(stall), .rev(rev), .heavy(heavy),
        .hot(hot), .cooled(cooled), .slow(slow), .light(light),
        .charge_dly(dly), .sense(sense));

    always #2 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            finish_test();
        end
    end

    function automatic int sw_cycles();
        return CLK_MHZ * 1000 / 2500;
    endfunction

    function automatic logic stall_ok(input int n);
        return n >= 64 * TICK_CYCLES && n <= 66 * TICK_CYCLES;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_phase(input bsfs_state_t exp);
        check(32'(phase), 32'(exp));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_phase(input bsfs_state_t p, input int lim);
        int i;
        for (i = 0; i < lim && phase !== p; i++) tick(1);
        check_phase(p);
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic start_reg();
        int t;
        int t1;
        int r;
        en = 1'b1;
        t = cycles;
        wait_phase(BSFS_LIN_FIRST, 20);
        tick(2);
        if (dly > 16'h0010) check(drive.precharge_on, 1);
        wait_phase(BSFS_RAMP, dly + 20);
        tick(2);
        check(drive.pulse_ilim, ILIM_HALF);
        rev = 1'b1; // Early reverse rail must be ignored in ramp
        tick(20);
        rev = 1'b0;
        tick(10);
        check_phase(BSFS_RAMP);
        @(posedge drive.switch_gate);
        t1 = cycles;
        @(posedge drive.switch_gate);
        check(cycles - t1, sw_cycles());
        r = drive.ref_level;
        tick(250);
        check(drive.ref_level - r, REF_STEP);
        wait_phase(BSFS_REGULATE, 20000);
        tick(2);
        check({drive.startup_done, drive.pulse_ilim}, {1'b1, ILIM_FULL});
        check(cycles - t <= TYP_START_US * TICK_CYCLES, 1);
        heavy = 1'b1;
        tick(100);
        check_phase(BSFS_REGULATE);
        rev = 1'b1;
        wait_phase(BSFS_FAULT, 12);
        tick(2);
        check({drive.fault_active, drive.switch_gate, drive.iso_input_on},
            3'h4);
        {en, rev, heavy} = 3'h0;
        wait_phase(BSFS_SHUTDOWN, 10);
    endtask

    initial begin
        int k;
        int t;
        tick(8);
        reset = 1'b0;
        tick(8);
        check_phase(BSFS_SHUTDOWN);
        check(drive, 0);
        for (k = 0; k < 3; k++) begin
            dly = (k == 0) ? 16'h0000 : 16'($unsigned($random(seed)) % 300);
            start_reg();
        end
        {stall, en, dly} = {2'h3, 16'h0010};
        {slow, light} = 2'h3;
        wait_phase(BSFS_RAMP, 60);
        t = cycles;
        tick(300);
        k = drive.ref_level;
        tick(250);
        check(drive.ref_level - k, REF_STEP_SLOW);
        @(posedge drive.switch_gate);
        k = cycles;
        @(posedge drive.switch_gate);
        check(cycles - k, 2 * sw_cycles());
        wait_phase(BSFS_FAULT, 17000);
        check(stall_ok(cycles - t), 1);
        {stall, en, dly} = {2'h0, 16'h03E8};
        {slow, light} = 2'h0;
        wait_phase(BSFS_SHUTDOWN, 10);
        en = 1'b1;
        wait_phase(BSFS_LIN_FIRST, 20);
        vin_ok = 1'b0;
        wait_phase(BSFS_FAULT, 12);
        {en, vin_ok} = 2'h1;
        wait_phase(BSFS_SHUTDOWN, 10);
        en = 1'b1;
        wait_phase(BSFS_LIN_FIRST, 20);
        hot = 1'b1;
        wait_phase(BSFS_THERMAL, 12);
        tick(2);
        check(drive.bias_on, 0);
        {hot, cooled} = 2'h1;
        wait_phase(BSFS_LIN_FIRST, 20);
        {en, cooled} = 2'h0;
        wait_phase(BSFS_SHUTDOWN, 10);
        finish_test();
    end
endmodule
